// ---- design/efl_pkg.sv ----
package efl_pkg;

  // Register byte offsets
  localparam logic [7:0] GLOBAL_FIRST_OFFS = 8'h40;
  localparam logic [7:0] GLOBAL_NEXT_OFFS  = 8'h44;
  localparam logic [7:0] HUB_FIRST_OFFS    = 8'h50;
  localparam logic [7:0] HUB_NEXT_OFFS     = 8'h52;

  // Reset values (only applied at power-on, flags are sticky)
  localparam logic [31:0] GLOBAL_RST = 32'h0000_0000;
  localparam logic [7:0]  HUB_RST    = 8'h00;

  // Global log field positions
  localparam int GBIT_DRAM_FAT = 27;
  localparam int GBIT_BUS_FAT  = 26;
  localparam int GBIT_HUB_FAT  = 25;
  localparam int GBIT_DMA_FAT  = 24;
  localparam int GBIT_PA_FAT   = 23;
  localparam int GBIT_PA1_FAT  = 22;
  localparam int GBIT_PB_FAT   = 21;
  localparam int GBIT_PB1_FAT  = 20;
  localparam int GBIT_PC_FAT   = 19;
  localparam int GBIT_PC1_FAT  = 18;
  localparam int GBIT_BUF_NF   = 14;
  localparam int GBIT_DRAM_NF  = 13;
  localparam int GBIT_BUS_NF   = 12;
  localparam int GBIT_HUB_NF   = 11;
  localparam int GBIT_DMA_NF   = 10;
  localparam int GBIT_PA_NF    = 9;
  localparam int GBIT_PA1_NF   = 8;
  localparam int GBIT_PB_NF    = 7;
  localparam int GBIT_PB1_NF   = 6;
  localparam int GBIT_PC_NF    = 5;
  localparam int GBIT_PC1_NF   = 4;

  // Implemented bits of the global logs
  localparam logic [31:0] GLOBAL_FAT_MASK = 32'h0ffc_0000;
  localparam logic [31:0] GLOBAL_NF_MASK  = 32'h0000_7ff0;

  // Hub-link log field positions
  localparam int HBIT_TABORT  = 6;
  localparam int HBIT_ECFG    = 5;
  localparam int HBIT_DPAR    = 4;
  localparam int HBIT_RANGE   = 3;
  localparam int HBIT_IPAR    = 2;
  localparam int HBIT_ILLEGAL = 1;
  localparam int HBIT_ACPAR   = 0;

  localparam logic [7:0] HUB_MASK     = 8'h7f;
  localparam logic [7:0] HUB_FAT_MASK = 8'h2b;

endpackage : efl_pkg

// ---- design/efl_error_log.sv ----
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// [R1] Port B1, C, C1 fatal at 20..18
// [R2] Bit 14 logs internal buffer non-fatal
// [R3] Bit 13 logs memory controller non-fatal
// [R4] Bit 12 logs system bus non-fatal
// [R5] Bit 11 logs hub link non-fatal
// [R6] Bit 10 logs DMA unit non-fatal
// [R7] Bits 9, 8 log ports A, A1
// [R8] Bits 7..4 log ports B..C1
// [R9] Flags sticky over reset, write one clears
// [R10] Next log mirrors first log layout
// [R11] Hub first log holds first error only
// [R12] Simultaneous first errors all latch together
// [R13] Hub bit 6 target abort, non-fatal
// [R14] Hub bit 5 config misroute, fatal
// [R15] Hub bit 4 data parity, non-fatal
// [R16] Hub bit 3 out of range, fatal
// [R17] Hub bit 2 internal parity, non-fatal
// [R18] Hub bit 1 illegal access, fatal
// [R19] Hub bit 0 address parity, fatal
// [R20] Fatal and non-fatal firsts captured separately
// [R21] Hub next log gathers later errors
// [R22] Logging ignores message enables
// [R23] Reserved bits read zero, ignore writes
// [R24] Hub errors roll up by class
module efl_error_log (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        pwr_on_rst_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  input  wire logic [8:0]  unit_fatal_i,
  input  wire logic [10:0] unit_nonfatal_i,
  input  wire logic [6:0]  hub_err_i
);

  logic [31:0] gfirst_q, gfirst_d;
  logic [31:0] gnext_q, gnext_d;
  logic [7:0]  hfirst_q, hfirst_d;
  logic [7:0]  hnext_q, hnext_d;
  logic [31:0] dat_d;
  logic        ack_d;
  logic        err_d;

  logic [31:0] gev;
  logic [31:0] gclr;
  logic [7:0]  hev;
  logic [7:0]  hclr_f;
  logic [7:0]  hclr_n;
  logic [31:0] wmask;
  logic        wr;
  logic        hit;
  logic [7:0]  byte_adr;
  logic        fat_free;
  logic        nf_free;
  logic        hub_free;

  always_comb begin
    byte_adr = {adr_i, 2'b00};
    wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    hit = (byte_adr == efl_pkg::GLOBAL_FIRST_OFFS) ||
          (byte_adr == efl_pkg::GLOBAL_NEXT_OFFS) ||
          (byte_adr == efl_pkg::HUB_FIRST_OFFS);
    wr = cyc_i && stb_i && we_i && hit && !(ack_o || err_o);
    hev = 8'h00;
    hev[efl_pkg::HBIT_TABORT]  = hub_err_i[6];                         // [R13]
    hev[efl_pkg::HBIT_ECFG]    = hub_err_i[5];                         // [R14]
    hev[efl_pkg::HBIT_DPAR]    = hub_err_i[4];                         // [R15]
    hev[efl_pkg::HBIT_RANGE]   = hub_err_i[3];                         // [R16]
    hev[efl_pkg::HBIT_IPAR]    = hub_err_i[2];                         // [R17]
    hev[efl_pkg::HBIT_ILLEGAL] = hub_err_i[1];                         // [R18]
    hev[efl_pkg::HBIT_ACPAR]   = hub_err_i[0];                         // [R19]

    // Hub-link events roll up into the hub unit bits by class
    gev = 32'h0000_0000;
    gev[efl_pkg::GBIT_DRAM_FAT] = unit_fatal_i[8];
    gev[efl_pkg::GBIT_BUS_FAT]  = unit_fatal_i[7];
    gev[efl_pkg::GBIT_HUB_FAT]  = |(hev & efl_pkg::HUB_FAT_MASK);      // [R24]
    gev[efl_pkg::GBIT_DMA_FAT]  = unit_fatal_i[6];
    gev[efl_pkg::GBIT_PA_FAT]   = unit_fatal_i[5];
    gev[efl_pkg::GBIT_PA1_FAT]  = unit_fatal_i[4];
    gev[efl_pkg::GBIT_PB_FAT]   = unit_fatal_i[3];
    gev[efl_pkg::GBIT_PB1_FAT]  = unit_fatal_i[2];                     // [R1]
    gev[efl_pkg::GBIT_PC_FAT]   = unit_fatal_i[1];                     // [R1]
    gev[efl_pkg::GBIT_PC1_FAT]  = unit_fatal_i[0];                     // [R1]
    gev[efl_pkg::GBIT_BUF_NF]   = unit_nonfatal_i[10];                 // [R2]
    gev[efl_pkg::GBIT_DRAM_NF]  = unit_nonfatal_i[9];                  // [R3]
    gev[efl_pkg::GBIT_BUS_NF]   = unit_nonfatal_i[8];                  // [R4]
    gev[efl_pkg::GBIT_HUB_NF]   = |(hev & ~efl_pkg::HUB_FAT_MASK)
                                  | unit_nonfatal_i[7];                // [R5] [R24]
    gev[efl_pkg::GBIT_DMA_NF]   = unit_nonfatal_i[6];                  // [R6]
    gev[efl_pkg::GBIT_PA_NF]    = unit_nonfatal_i[5];                  // [R7]
    gev[efl_pkg::GBIT_PA1_NF]   = unit_nonfatal_i[4];                  // [R7]
    gev[efl_pkg::GBIT_PB_NF]    = unit_nonfatal_i[3];                  // [R8]
    gev[efl_pkg::GBIT_PB1_NF]   = unit_nonfatal_i[2];                  // [R8]
    gev[efl_pkg::GBIT_PC_NF]    = unit_nonfatal_i[1];                  // [R8]
    gev[efl_pkg::GBIT_PC1_NF]   = unit_nonfatal_i[0];                  // [R8]

    gclr = 32'h0000_0000;
    hclr_f = 8'h00;
    hclr_n = 8'h00;
    if (wr && byte_adr == efl_pkg::GLOBAL_FIRST_OFFS) begin
      gclr = dat_i & wmask;                                            // [R9]
    end
    if (wr && byte_adr == efl_pkg::HUB_FIRST_OFFS) begin
      // Both hub logs share one word: first in lane 0, next in lane 2
      hclr_f = sel_i[0] ? dat_i[7:0] : 8'h00;                          // [R9]
      hclr_n = sel_i[2] ? dat_i[23:16] : 8'h00;                        // [R9]
    end

    // Capture slots judged on the registered value, before this clear
    fat_free = (gfirst_q & efl_pkg::GLOBAL_FAT_MASK) == 32'h0000_0000;
    nf_free  = (gfirst_q & efl_pkg::GLOBAL_NF_MASK) == 32'h0000_0000;
    hub_free = hfirst_q == 8'h00;

    // Clear wins over set (a set bit blocks capture); all same-cycle firsts latch together
    gfirst_d = gfirst_q & ~gclr;
    if (fat_free) begin
      gfirst_d = gfirst_d | (gev & efl_pkg::GLOBAL_FAT_MASK);          // [R20] [R12]
    end
    if (nf_free) begin
      gfirst_d = gfirst_d | (gev & efl_pkg::GLOBAL_NF_MASK);           // [R20] [R12]
    end
    gfirst_d = gfirst_d & (efl_pkg::GLOBAL_FAT_MASK
                           | efl_pkg::GLOBAL_NF_MASK);                 // [R23]

    gnext_d = gnext_q;
    if (wr && byte_adr == efl_pkg::GLOBAL_NEXT_OFFS) begin
      gnext_d = gnext_q & ~(dat_i & wmask);                            // [R10]
    end
    if (!fat_free) begin
      gnext_d = gnext_d | (gev & efl_pkg::GLOBAL_FAT_MASK);            // [R10]
    end
    if (!nf_free) begin
      gnext_d = gnext_d | (gev & efl_pkg::GLOBAL_NF_MASK);             // [R10]
    end
    gnext_d = gnext_d & (efl_pkg::GLOBAL_FAT_MASK
                         | efl_pkg::GLOBAL_NF_MASK);                   // [R23]

    // Enables play no part: every reported event is logged
    hfirst_d = (hfirst_q & ~hclr_f)
               | (hub_free ? hev : 8'h00);                             // [R11] [R12] [R22]
    hnext_d  = ((hnext_q & ~hclr_n)
               | (hub_free ? 8'h00 : hev)) & efl_pkg::HUB_MASK;        // [R21] [R23]

    ack_d = 1'b0;
    err_d = 1'b0;
    dat_d = 32'h0000_0000;
    if (cyc_i && stb_i && !ack_o && !err_o) begin
      ack_d = hit;
      err_d = !hit;
      case (byte_adr)
        efl_pkg::GLOBAL_FIRST_OFFS: dat_d = gfirst_q;
        efl_pkg::GLOBAL_NEXT_OFFS:  dat_d = gnext_q;
        efl_pkg::HUB_FIRST_OFFS:    dat_d = {8'h00, hnext_q, 8'h00, hfirst_q};
        default:                    dat_d = 32'h0000_0000;
      endcase
    end
  end

  // Logs use a separate power-on reset: rst_i leaves them alone
  always_ff @(posedge clk_i) begin
    if (pwr_on_rst_i) begin
      gfirst_q <= efl_pkg::GLOBAL_RST;
      gnext_q  <= efl_pkg::GLOBAL_RST;
      hfirst_q <= efl_pkg::HUB_RST;
      hnext_q  <= efl_pkg::HUB_RST;
    end else begin
      gfirst_q <= gfirst_d;                                            // [R9]
      gnext_q  <= gnext_d;
      hfirst_q <= hfirst_d;
      hnext_q  <= hnext_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= ack_d;
      err_o <= err_d;
      dat_o <= dat_d;
    end
  end

endmodule : efl_error_log

`default_nettype wire

// ---- bench/efl_error_log_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module efl_error_log_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        pwr_on_rst_i,
  input wire logic [5:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0]  sel_i,
  input wire logic        we_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic [8:0]  unit_fatal_i,
  input wire logic [10:0] unit_nonfatal_i,
  input wire logic [6:0]  hub_err_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic map_w;
  assign map_w = adr_i inside {6'h10, 6'h11, 6'h14};
  sequence req_s;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence glob_rd_s;
    ack_o && $past(adr_i[5:1]) == 5'h08;
  endsequence
  a_ack_mapped: assert property (req_s ##0 map_w |=> ack_o && !err_o)
    else $error("mapped access not acked");
  a_err_unmapped: assert property (req_s ##0 !map_w |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  a_ans_pulse: assert property (ack_o || err_o |=> !ack_o && !err_o)
    else $error("answer longer than one cycle");
  a_idle_quiet: assert property (!(cyc_i && stb_i) |=> !(ack_o || err_o))
    else $error("answer without request");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside answer");
  a_glob_rsvd: assert property (glob_rd_s |-> (dat_o & 32'hf003_800f) == 32'h0)
    else $error("global reserved bit set");
  a_hub_rsvd: assert property (ack_o && $past(adr_i) == 6'h14 |->
    (dat_o & 32'hff80_ff80) == 32'h0)
    else $error("hub reserved bit set");
  a_err_nodata: assert property (err_o |-> dat_o == 32'h0)
    else $error("refused access returned data");
endmodule : efl_error_log_props
bind efl_error_log efl_error_log_props u_props (.clk_i, .rst_i, .pwr_on_rst_i,
  .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o, .err_o,
  .unit_fatal_i, .unit_nonfatal_i, .hub_err_i);
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk_i, rst_i, pwr_on_rst_i, we_i, cyc_i, stb_i, ack_o, err_o;
  logic        eb;
  logic [5:0]  adr_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [3:0]  sel_i;
  logic [8:0]  unit_fatal_i;
  logic [6:0]  hub_err_i;
  logic [10:0] unit_nonfatal_i;
  int          n_fail, check_count;
  efl_error_log uut (.clk_i, .rst_i, .pwr_on_rst_i, .adr_i, .dat_i, .sel_i,
    .we_i, .cyc_i, .stb_i, .dat_o, .ack_o, .err_o, .unit_fatal_i,
    .unit_nonfatal_i, .hub_err_i);
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= s;
    // Answer and data taken at the rising edge that samples them
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && i < 20);
    if (ack_o !== 1'b1 && err_o !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    rd = dat_o;
    eb = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : bus
  task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, 4'hf);
    chk(nm, e, rd);
  endtask : rc
  task automatic ev(input logic [8:0] f, input logic [10:0] n,
                    input logic [6:0] h);
    @(posedge clk_i);
    unit_fatal_i <= f;
    unit_nonfatal_i <= n;
    hub_err_i <= h;
    @(posedge clk_i);
    unit_fatal_i <= 9'h000;
    unit_nonfatal_i <= 11'h000;
    hub_err_i <= 7'h00;
  endtask : ev
  initial begin
    {rst_i, pwr_on_rst_i} = 2'b11;
    {we_i, cyc_i, stb_i, adr_i, dat_i, sel_i} = '0;
    {unit_fatal_i, unit_nonfatal_i, hub_err_i} = '0;
    repeat (4) @(posedge clk_i);
    {rst_i, pwr_on_rst_i} <= 2'b00;
    rc("gfirst", 6'h10, 32'h0);
    rc("gnext", 6'h11, 32'h0);
    rc("hub", 6'h14, 32'h0);
    $display("test reset done");
    ev(9'h1ff, 11'h7ff, 7'h00);
    rc("gfirst", 6'h10, 32'h0dfc_7ff0);
    ev(9'h000, 11'h200, 7'h10);
    ev(9'h000, 11'h000, 7'h7f);
    rc("gnext", 6'h11, 32'h0200_2800);
    rc("hub", 6'h14, 32'h007f_0010);
    $display("test logging done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rc("gfirst sticky", 6'h10, 32'h0dfc_7ff0);
    bus(6'h10, 1'b1, 32'h0, 4'hf);
    bus(6'h10, 1'b1, 32'hffff_ffff, 4'h2);
    rc("gfirst lane", 6'h10, 32'h0dfc_00f0);
    bus(6'h10, 1'b1, 32'hffff_ffff, 4'hf);
    bus(6'h14, 1'b1, 32'hffff_ffff, 4'h1);
    ev(9'h000, 11'h100, 7'h20);
    rc("gfirst again", 6'h10, 32'h0200_1000);
    rc("hub again", 6'h14, 32'h007f_0020);
    $display("test clear done");
    bus(6'h3f, 1'b1, 32'hffff_ffff, 4'hf);
    chk("err", 32'h1, {31'h0, eb});
    rc("gnext kept", 6'h11, 32'h0200_2800);
    $display("test unmapped done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
